// [hdl/tmr_pkg.sv]
package tmr_pkg;

  localparam int          NUM_CH     = 4;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;

  // Word-aligned register offsets on the bus
  localparam logic [7:0]  OFS_SYS    = 8'h00;
  localparam logic [7:0]  OFS_TOGGLE = 8'h04;
  localparam logic [7:0]  OFS_ACTION = 8'h08;

  // Field positions in timer_system_control_one, and the write masks of it and the toggle register
  localparam int          SYS_EN_BIT   = 7;
  localparam int          SYS_FAST_BIT = 4;
  localparam logic [7:0]  SYS_WMASK    = 8'h90;
  localparam logic [7:0]  TOGGLE_WMASK = 8'h0f;

  // Reset values
  localparam logic [7:0]  RST_SYS    = 8'h00;
  localparam logic [7:0]  RST_TOGGLE = 8'h00;
  localparam logic [7:0]  RST_ACTION = 8'h00;
  localparam logic        RST_PIN    = 1'b0;

  // Output action encodings
  localparam logic [1:0]  ACT_DISC   = 2'b00;
  localparam logic [1:0]  ACT_TOGGLE = 2'b01;
  localparam logic [1:0]  ACT_LOW    = 2'b10;
  localparam logic [1:0]  ACT_HIGH   = 2'b11;

  localparam int          OVR_CH     = 3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

  typedef struct packed {
    logic       cc_sel;
    logic [1:0] action;
    logic       toggle_on_overflow;
    logic       ovr_mask;
    logic       ovr_data;
    logic       ddr;
  } chan_cfg_s;

  typedef struct packed {
    logic [3:0] chan;
    logic       counter_ovf;
    logic       accum_ovf;
    logic       accum_in;
  } flag_clr_s;

  // Mode bit at 2n+1, level bit at 2n
  function automatic logic [1:0] action_of(input logic [7:0] r, input int n);
    return r[2*n+1 -: 2];
  endfunction

endpackage

// [hdl/pin_action.sv]
`timescale 1ns/1ps
module pin_action (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Configuration
  input  wire logic              run,
  input  tmr_pkg::chan_cfg_s     cfg,
  // Events
  input  wire logic              ovf,
  input  wire logic              cmp,
  input  wire logic              force_cmp,
  input  wire logic              ovr_hit,
  // Pin
  output logic                   pin_out,
  output logic                   pin_oe
);
  import tmr_pkg::*;

  logic next_pin;
  logic next_oe;

  always_comb begin
    next_pin = pin_out;
    if (run && cfg.cc_sel) begin
      if (ovr_hit) begin
        next_pin = cfg.ovr_data;
      end else if (cfg.toggle_on_overflow && ovf) begin
        next_pin = ~pin_out;
      end else if (cmp || force_cmp) begin
        case (cfg.action)
          ACT_TOGGLE: next_pin = ~pin_out;
          ACT_LOW:    next_pin = 1'b0;
          ACT_HIGH:   next_pin = 1'b1;
          default:    next_pin = pin_out;
        endcase
      end
    end
    // Timer takes the pin on a compare channel with a non-disconnect action or override mask set, or whenever ddr is set
    next_oe = (cfg.cc_sel && (cfg.action != ACT_DISC || cfg.ovr_mask)) || cfg.ddr;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= RST_PIN;
      pin_oe  <= 1'b0;
    end else begin
      pin_out <= next_pin;
      pin_oe  <= next_oe;
    end
  end

  a_tov_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    (run && cfg.cc_sel && cfg.toggle_on_overflow && ovf && !ovr_hit) |=> (pin_out != $past(pin_out)))
    else $error("overflow toggle missed");

  a_capture_ignores: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg.cc_sel) |=> (pin_out == $past(pin_out)))
    else $error("capture channel pin changed");

  a_override_wins: assert property (@(posedge clk) disable iff (!rst_n)
    (run && cfg.cc_sel && ovr_hit) |=> (pin_out == $past(cfg.ovr_data)))
    else $error("override data not taken");

  a_tov_over_force: assert property (@(posedge clk) disable iff (!rst_n)
    (run && cfg.cc_sel && cfg.toggle_on_overflow && ovf && force_cmp && !ovr_hit && cfg.action == ACT_HIGH && !pin_out)
    |=> pin_out)
    else $error("overflow toggle lost to force");

  a_action_low: assert property (@(posedge clk) disable iff (!rst_n)
    (run && cfg.cc_sel && cmp && !ovf && !ovr_hit && cfg.action == ACT_LOW) |=> !pin_out)
    else $error("clear action failed");

  a_action_disc: assert property (@(posedge clk) disable iff (!rst_n)
    (run && cfg.cc_sel && cmp && !ovf && !ovr_hit && cfg.action == ACT_DISC) |=> $stable(pin_out))
    else $error("disconnected pin changed");

  a_oe_forced: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg.cc_sel && cfg.action != ACT_DISC) ##1 (cfg.cc_sel && cfg.action != ACT_DISC) |-> pin_oe)
    else $error("output enable not forced");

endmodule

// [hdl/timer_ctrl.sv]
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module timer_ctrl #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input  wire logic                         MCLK,
  input  wire logic                         RST_N,
  // Wishbone slave
  input  wire logic                         WB_CYC_I,
  input  wire logic                         WB_STB_I,
  input  wire logic                         WB_WE_I,
  input  wire logic [tmr_pkg::ADDR_W-1:0]   WB_ADR_I,
  input  wire logic [3:0]                   WB_SEL_I,
  input  wire logic [tmr_pkg::DATA_W-1:0]   WB_DAT_I,
  output logic      [tmr_pkg::DATA_W-1:0]   WB_DAT_O,
  output logic                              WB_ACK_O,
  // Timer core
  output logic                              TIMER_RUN,
  input  wire logic                         CNT_OVF,
  input  wire logic [3:0]                   CMP_EVT,
  input  wire logic [3:0]                   FORCE_CMP,
  input  wire logic [3:0]                   CC_SELECT,
  input  wire logic [3:0]                   OVR_MASK,
  input  wire logic [3:0]                   OVR_DATA,
  input  wire logic [3:0]                   PIN_DIR,
  // Register access strobes
  input  wire logic [3:0]                   CAPT_READ,
  input  wire logic [3:0]                   CMP_WRITE,
  input  wire logic                         COUNT_ACCESS,
  input  wire logic                         ACCUM_ACCESS,
  input  wire logic [3:0]                   CHAN_FLAG_W1,
  input  wire logic                         OVF_FLAG_W1,
  input  wire logic [1:0]                   ACCUM_FLAG_W1,
  // Flag clears
  output tmr_pkg::flag_clr_s                FLAG_CLR,
  // Channel pins
  output logic      [3:0]                   PIN_OUT,
  output logic      [3:0]                   PIN_OE
);
  import tmr_pkg::*;

  if (CHANNELS != NUM_CH) begin : g_bad_channels
    $error("CHANNELS must be 4");
  end

  bus_state_e             state;
  bus_state_e             next_state;
  logic [7:0]             sys_ctrl;
  logic [7:0]             next_sys_ctrl;
  logic [7:0]             toggle_en;
  logic [7:0]             next_toggle_en;
  logic [7:0]             out_action;
  logic [7:0]             next_out_action;
  logic [DATA_W-1:0]      next_dat;
  flag_clr_s              next_clr;
  logic                   req;
  logic                   wr_take;
  logic                   fast;
  logic                   run;
  chan_cfg_s [3:0]        cfg;
  logic [3:0]             ovr_hit;

  assign req       = WB_CYC_I && WB_STB_I;
  assign WB_ACK_O  = (state == BUS_ACK) && req;
  // Write lands on the edge where the master samples ack
  assign wr_take   = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  assign fast      = sys_ctrl[SYS_FAST_BIT];
  assign run       = sys_ctrl[SYS_EN_BIT];
  assign TIMER_RUN = run;

  // Bus handshake
  always_comb begin
    next_state = state;
    case (state)
      BUS_IDLE: begin
        if (req) begin
          next_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        next_state = BUS_IDLE;
      end
      default: begin
        next_state = BUS_IDLE;
      end
    endcase
  end

  // Register writes and read mux
  always_comb begin
    next_sys_ctrl   = sys_ctrl;
    next_toggle_en  = toggle_en;
    next_out_action = out_action;
    next_dat        = WB_DAT_O;
    if (wr_take) begin
      if (WB_ADR_I == OFS_SYS) begin
        next_sys_ctrl = WB_DAT_I[7:0] & SYS_WMASK;
      end else if (WB_ADR_I == OFS_TOGGLE) begin
        next_toggle_en = WB_DAT_I[7:0] & TOGGLE_WMASK;
      end else if (WB_ADR_I == OFS_ACTION) begin
        next_out_action = WB_DAT_I[7:0];
      end
    end
    if (state == BUS_IDLE && req) begin
      if (WB_ADR_I == OFS_SYS) begin
        next_dat = {24'h000000, sys_ctrl};
      end else if (WB_ADR_I == OFS_TOGGLE) begin
        next_dat = {24'h000000, toggle_en};
      end else if (WB_ADR_I == OFS_ACTION) begin
        next_dat = {24'h000000, out_action};
      end else begin
        next_dat = 32'h00000000;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state      <= BUS_IDLE;
      sys_ctrl   <= RST_SYS;
      toggle_en  <= RST_TOGGLE;
      out_action <= RST_ACTION;
      WB_DAT_O   <= 32'h00000000;
    end else begin
      state      <= next_state;
      sys_ctrl   <= next_sys_ctrl;
      toggle_en  <= next_toggle_en;
      out_action <= next_out_action;
      WB_DAT_O   <= next_dat;
    end
  end

  // Flag clear selection
  always_comb begin
    if (fast) begin
      next_clr.chan        = CAPT_READ | CMP_WRITE;
      next_clr.counter_ovf = COUNT_ACCESS;
      next_clr.accum_ovf   = ACCUM_ACCESS;
      next_clr.accum_in    = ACCUM_ACCESS;
    end else begin
      next_clr.chan        = CHAN_FLAG_W1;
      next_clr.counter_ovf = OVF_FLAG_W1;
      next_clr.accum_ovf   = ACCUM_FLAG_W1[1];
      next_clr.accum_in    = ACCUM_FLAG_W1[0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAG_CLR <= '0;
    end else begin
      FLAG_CLR <= next_clr;
    end
  end

  // Per-channel pin control; one process so each vector has a single driver
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      cfg[n].cc_sel   = CC_SELECT[n];
      cfg[n].action   = action_of(out_action, n);
      cfg[n].toggle_on_overflow      = toggle_en[n];
      cfg[n].ovr_mask = OVR_MASK[n];
      cfg[n].ovr_data = OVR_DATA[n];
      cfg[n].ddr      = PIN_DIR[n];
      ovr_hit[n]      = CMP_EVT[OVR_CH] && CC_SELECT[OVR_CH] && OVR_MASK[n];
    end
  end

  for (genvar n = 0; n < NUM_CH; n++) begin : g_chan
    pin_action u_pin (
      .clk       (MCLK),
      .rst_n     (RST_N),
      .run       (run),
      .cfg       (cfg[n]),
      .ovf       (CNT_OVF),
      .cmp       (CMP_EVT[n]),
      .force_cmp (FORCE_CMP[n]),
      .ovr_hit   (ovr_hit[n]),
      .pin_out   (PIN_OUT[n]),
      .pin_oe    (PIN_OE[n])
    );
  end

  a_ack_single: assert property (@(posedge MCLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");

  a_ack_latency: assert property (@(posedge MCLK) disable iff (!RST_N)
    (req && !WB_ACK_O && state == BUS_IDLE) ##1 req |-> WB_ACK_O)
    else $error("ack not one cycle after request");

  a_enable_stop: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_take && WB_ADR_I == OFS_SYS && !WB_DAT_I[SYS_EN_BIT]) |=> !TIMER_RUN)
    else $error("timer not stopped by enable clear");

  a_enable_start: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_take && WB_ADR_I == OFS_SYS && WB_DAT_I[SYS_EN_BIT]) |=> TIMER_RUN [*1] ##1 (TIMER_RUN || WB_ACK_O))
    else $error("timer not started by enable set");

  a_fast_chan: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fast && (CAPT_READ | CMP_WRITE) != 4'h0) |=> FLAG_CLR.chan == ($past(CAPT_READ) | $past(CMP_WRITE)))
    else $error("fast channel clear wrong");

  a_fast_count: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fast && COUNT_ACCESS) |=> FLAG_CLR.counter_ovf)
    else $error("counter access did not clear overflow");

  a_fast_accum: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fast && ACCUM_ACCESS) |=> (FLAG_CLR.accum_ovf && FLAG_CLR.accum_in))
    else $error("accumulator access did not clear flags");

  a_w1c_blocked: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fast && !COUNT_ACCESS && OVF_FLAG_W1) |=> !FLAG_CLR.counter_ovf)
    else $error("write-one cleared under fast clear");

  a_w1c_normal: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!fast) |=> (FLAG_CLR.chan == $past(CHAN_FLAG_W1) && FLAG_CLR.accum_in == $past(ACCUM_FLAG_W1[0])))
    else $error("write-one clear not passed");

  a_reserved_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_SYS) |-> (WB_DAT_O[6:5] == 2'b00 && WB_DAT_O[3:0] == 4'h0))
    else $error("reserved control bits nonzero");

  a_reg_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    !wr_take |=> $stable(TIMER_RUN))
    else $error("enable changed without a write");

  a_read_run: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_SYS) |-> (WB_DAT_O[SYS_EN_BIT] == TIMER_RUN))
    else $error("enable bit read back wrong");

  a_stop_holds_pins: assert property (@(posedge MCLK) disable iff (!RST_N)
    !TIMER_RUN |=> $stable(PIN_OUT))
    else $error("pins moved while timer stopped");

  a_fast_bit_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_take && WB_ADR_I == OFS_SYS) |=> (fast == $past(WB_DAT_I[SYS_FAST_BIT])))
    else $error("fast clear bit not written");

  a_fast_chan_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fast && CAPT_READ == 4'h0 && CMP_WRITE == 4'h0) |=> (FLAG_CLR.chan == 4'h0))
    else $error("channel clear without access");

  a_fast_accum_idle: assert property (@(posedge MCLK) disable iff (!RST_N)
    (fast && !ACCUM_ACCESS) |=> (!FLAG_CLR.accum_ovf && !FLAG_CLR.accum_in))
    else $error("accumulator clear without access");

  a_accum_pair: assert property (@(posedge MCLK) disable iff (!RST_N)
    fast |=> (FLAG_CLR.accum_ovf == FLAG_CLR.accum_in))
    else $error("accumulator flags cleared apart");

  a_w1c_ovf_normal: assert property (@(posedge MCLK) disable iff (!RST_N)
    !fast |=> (FLAG_CLR.counter_ovf == $past(OVF_FLAG_W1)))
    else $error("overflow write-one clear not passed");

  a_w1c_accovf: assert property (@(posedge MCLK) disable iff (!RST_N)
    !fast |=> (FLAG_CLR.accum_ovf == $past(ACCUM_FLAG_W1[1])))
    else $error("accumulator overflow write-one clear not passed");

  a_slow_count_access: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!fast && COUNT_ACCESS && !OVF_FLAG_W1) |=> !FLAG_CLR.counter_ovf)
    else $error("counter access cleared overflow with fast clear off");

  a_slow_accum_access: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!fast && ACCUM_ACCESS && ACCUM_FLAG_W1 == 2'b00) |=> !FLAG_CLR.accum_ovf)
    else $error("accumulator access cleared flag with fast clear off");

  a_override_pin0: assert property (@(posedge MCLK) disable iff (!RST_N)
    (TIMER_RUN && CMP_EVT[OVR_CH] && CC_SELECT[OVR_CH] && CC_SELECT[0] && OVR_MASK[0])
    |=> (PIN_OUT[0] == $past(OVR_DATA[0])))
    else $error("channel 0 override not taken");

  a_capture_pin1: assert property (@(posedge MCLK) disable iff (!RST_N)
    !CC_SELECT[1] |=> $stable(PIN_OUT[1]))
    else $error("capture channel 1 pin changed");

  a_oe_dir: assert property (@(posedge MCLK) disable iff (!RST_N)
    PIN_DIR[0] ##1 PIN_DIR[0] |-> PIN_OE[0])
    else $error("direction bit not honoured");

  a_oe_mask: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CC_SELECT[OVR_CH] && OVR_MASK[OVR_CH]) ##1 (CC_SELECT[OVR_CH] && OVR_MASK[OVR_CH]) |-> PIN_OE[OVR_CH])
    else $error("override mask did not drive pin");

  a_oe_release: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!CC_SELECT[0] && !PIN_DIR[0]) ##1 (!CC_SELECT[0] && !PIN_DIR[0]) |-> !PIN_OE[0])
    else $error("capture pin still driven");

  a_unmapped_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WB_ACK_O && !WB_WE_I && WB_ADR_I != OFS_SYS && WB_ADR_I != OFS_TOGGLE && WB_ADR_I != OFS_ACTION)
    |-> (WB_DAT_O == '0))
    else $error("unmapped read nonzero");

  a_toggle_rsv: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WB_ACK_O && !WB_WE_I && WB_ADR_I == OFS_TOGGLE) |-> (WB_DAT_O[DATA_W-1:NUM_CH] == '0))
    else $error("reserved toggle bits nonzero");

endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import tmr_pkg::*;
  logic              mclk, rst_n, cyc, stb, we, run, cnt_ovf, cnt_acc, acc_acc, ovf_w1;
  logic [7:0]        adr;
  logic [3:0]        sel, cmp_evt, force_cmp, cc_sel, ovr_mask, ovr_data, pin_dir;
  logic [3:0]        capt_rd, cmp_wr, chan_w1, pin_out, pin_oe;
  logic [1:0]        acc_w1;
  logic [31:0]       dat_i, dat_o;
  logic              ack;
  flag_clr_s         flag_clr;
  int                failures = 0;
  int                checks_done = 0;

  timer_ctrl #(.CHANNELS(4)) DUT (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .TIMER_RUN(run), .CNT_OVF(cnt_ovf), .CMP_EVT(cmp_evt), .FORCE_CMP(force_cmp), .CC_SELECT(cc_sel),
    .OVR_MASK(ovr_mask), .OVR_DATA(ovr_data), .PIN_DIR(pin_dir), .CAPT_READ(capt_rd), .CMP_WRITE(cmp_wr),
    .COUNT_ACCESS(cnt_acc), .ACCUM_ACCESS(acc_acc), .CHAN_FLAG_W1(chan_w1), .OVF_FLAG_W1(ovf_w1),
    .ACCUM_FLAG_W1(acc_w1), .FLAG_CLR(flag_clr), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; the request is held until ack is seen high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; dat_i <= d; sel <= 4'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'h1);
    q = dat_o;
    cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
    chk("ack edges", 32'h2, n);
    @(negedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'h1, a, {24'h0, d}, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    wb(1'h0, a, 32'h0, q);
    chk("read data", {24'h0, exp}, q);
  endtask

  task automatic fc(input logic [3:0] cr, input logic [3:0] cw, input logic ca, input logic aa,
                    input logic [3:0] cf, input logic of, input logic [1:0] af, input logic [6:0] exp);
    @(posedge mclk);
    capt_rd <= cr; cmp_wr <= cw; cnt_acc <= ca; acc_acc <= aa; chan_w1 <= cf; ovf_w1 <= of; acc_w1 <= af;
    @(posedge mclk);
    capt_rd <= 4'h0; cmp_wr <= 4'h0; cnt_acc <= 1'h0; acc_acc <= 1'h0; chan_w1 <= 4'h0; ovf_w1 <= 1'h0;
    acc_w1 <= 2'h0;
    @(negedge mclk);
    chk("flag clear", {25'h0, exp}, {25'h0, flag_clr});
  endtask

  task automatic ev(input logic ovf, input logic [3:0] cmp, input logic [3:0] frc, input logic [3:0] exp);
    @(posedge mclk);
    cnt_ovf <= ovf; cmp_evt <= cmp; force_cmp <= frc;
    @(posedge mclk);
    cnt_ovf <= 1'h0; cmp_evt <= 4'h0; force_cmp <= 4'h0;
    @(negedge mclk);
    chk("pin out", {28'h0, exp}, {28'h0, pin_out});
  endtask

  task automatic t_regs;
    rdc(OFS_SYS, 8'h00);
    rdc(OFS_TOGGLE, 8'h00);
    rdc(OFS_ACTION, 8'h00);
    wr(OFS_SYS, 8'hff);
    rdc(OFS_SYS, 8'h90);
    chk("timer run", 32'h1, {31'h0, run});
    wr(OFS_TOGGLE, 8'hff);
    rdc(OFS_TOGGLE, 8'h0f);
    wr(OFS_ACTION, 8'ha5);
    rdc(OFS_ACTION, 8'ha5);
    wr(8'h0c, 8'h5a);
    rdc(8'h0c, 8'h00);
  endtask

  task automatic t_fast;
    fc(4'h1, 4'h0, 1'h0, 1'h0, 4'h0, 1'h0, 2'h0, 7'h08);
    fc(4'h0, 4'h8, 1'h0, 1'h0, 4'h0, 1'h0, 2'h0, 7'h40);
    fc(4'h0, 4'h0, 1'h1, 1'h0, 4'h0, 1'h0, 2'h0, 7'h04);
    fc(4'h0, 4'h0, 1'h0, 1'h1, 4'h0, 1'h0, 2'h0, 7'h03);
    fc(4'h0, 4'h0, 1'h0, 1'h0, 4'hf, 1'h1, 2'h3, 7'h00);
    wr(OFS_SYS, 8'h80);
    fc(4'hf, 4'hf, 1'h1, 1'h1, 4'h0, 1'h0, 2'h0, 7'h00);
    fc(4'h0, 4'h0, 1'h0, 1'h0, 4'h5, 1'h1, 2'h2, 7'h2e);
  endtask

  task automatic t_toggle;
    wr(OFS_ACTION, 8'h00);
    @(posedge mclk);
    cc_sel <= 4'h5;
    ev(1'h1, 4'h0, 4'h0, 4'h5);
    wr(OFS_SYS, 8'h00);
    chk("timer run", 32'h0, {31'h0, run});
    ev(1'h1, 4'h0, 4'h0, 4'h5);
    wr(OFS_SYS, 8'h80);
  endtask

  task automatic t_prio;
    wr(OFS_ACTION, 8'h03);
    ev(1'h1, 4'h0, 4'h1, 4'h0);
    @(posedge mclk);
    cc_sel <= 4'hd; ovr_mask <= 4'h1; ovr_data <= 4'h0;
    ev(1'h1, 4'h8, 4'h0, 4'hc);
  endtask

  task automatic t_action;
    wr(OFS_TOGGLE, 8'h00);
    wr(OFS_ACTION, 8'he4);
    @(posedge mclk);
    cc_sel <= 4'hf; ovr_mask <= 4'h0;
    ev(1'h0, 4'hf, 4'h0, 4'ha);
    ev(1'h0, 4'h0, 4'h2, 4'h8);
    chk("pin enable", 32'he, {28'h0, pin_oe});
    @(posedge mclk);
    cc_sel <= 4'h0; pin_dir <= 4'h1;
    ev(1'h0, 4'hf, 4'h0, 4'h8);
    chk("pin enable", 32'h1, {28'h0, pin_oe});
    wr(OFS_ACTION, 8'h24);
    @(posedge mclk);
    cc_sel <= 4'h8; pin_dir <= 4'h0; ovr_mask <= 4'h8;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("pin enable", 32'h8, {28'h0, pin_oe});
    @(posedge mclk);
    ovr_mask <= 4'h0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk("pin enable", 32'h0, {28'h0, pin_oe});
    ev(1'h0, 4'h8, 4'h0, 4'h8);
  endtask

  initial begin
    rst_n = 1'h0; cyc = 1'h0; stb = 1'h0; we = 1'h0; adr = 8'h00; sel = 4'h0; dat_i = 32'h0;
    cnt_ovf = 1'h0; cmp_evt = 4'h0; force_cmp = 4'h0; cc_sel = 4'h0; ovr_mask = 4'h0; ovr_data = 4'h0;
    pin_dir = 4'h0; capt_rd = 4'h0; cmp_wr = 4'h0; cnt_acc = 1'h0; acc_acc = 1'h0; chan_w1 = 4'h0;
    ovf_w1 = 1'h0; acc_w1 = 2'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    t_regs;
    t_fast;
    t_toggle;
    t_prio;
    t_action;
    end_of_test;
  end

  initial begin
    #200000;
    failures++;
    end_of_test;
  end
endmodule
